// file: hw/ots_pkg.sv
// Purpose: constants for the output three product one select block
// Assumes: registers sit at byte address four times their index
// Notes: nonvolatile copies sit at index plus the nonvolatile base
package ots_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int SEL_W = 25;
  localparam int NV_AW = 3;
  localparam int NV_WORDS = 5;
  localparam logic [15:0] IDX_SEL_A = 16'h0016;
  localparam logic [15:0] IDX_SEL_B = 16'h0017;
  localparam logic [15:0] IDX_SEL_C = 16'h0018;
  localparam logic [15:0] IDX_SEL_D = 16'h001C;
  localparam logic [15:0] IDX_MR_MAP = 16'h0040;
  localparam logic [15:0] IDX_LOAD = 16'h0050;
  localparam logic [15:0] IDX_STATUS = 16'h0051;
  localparam logic [15:0] NV_BASE = 16'h8000;
  localparam int MR_MAP_BIT = 2;
  localparam int LOAD_GO_BIT = 0;
  localparam int ST_OUT_BIT = 0;
  localparam int ST_TERM1_BIT = 1;
  localparam int ST_TERM2_BIT = 2;
  localparam int ST_MR_BIT = 3;
  localparam int ST_LOAD_BIT = 4;
  localparam logic [7:0] SEL_A_RST = 8'h00;
  localparam logic [7:0] SEL_B_RST = 8'h00;
  localparam logic [7:0] SEL_C_RST = 8'h00;
  localparam logic [7:0] SEL_D_RST = 8'h00;
  localparam logic [7:0] MR_MAP_RST = 8'h00;
  localparam logic [2:0] SLOT_A = 3'h0;
  localparam logic [2:0] SLOT_B = 3'h1;
  localparam logic [2:0] SLOT_C = 3'h2;
  localparam logic [2:0] SLOT_D = 3'h3;
  localparam logic [2:0] SLOT_MR = 3'h4;
  localparam logic [2:0] SLOT_LAST = 3'h4;
  localparam int SYNC_W = 17;
endpackage

// file: hw/ots_nv_store.sv
// Purpose: nonvolatile copy store for the select registers
// Assumes: one write port and one read port on the same clock
// Notes: contents are not cleared by reset; unwritten words read unknown
`timescale 1ns/1ns
module ots_nv_store (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [ots_pkg::NV_AW-1:0] wr_addr,
  input wire logic [ots_pkg::REG_W-1:0] wr_data,
  input wire logic [ots_pkg::NV_AW-1:0] rd_addr,
  output logic [ots_pkg::REG_W-1:0] rd_data_q
);
  logic [ots_pkg::REG_W-1:0] mem_q [0:(1 << ots_pkg::NV_AW)-1];
  logic [ots_pkg::REG_W-1:0] rd_data_d;

  always_comb begin
    rd_data_d = mem_q[rd_addr];
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data_q <= rd_data_d;
  end
endmodule

// file: hw/ots_select.sv
// Purpose: product one selection and output three for the sequencer
// Assumes: avalon slave with byte addresses, 8-bit registers in lane 0
// Notes: outputs, term two and manual reset status come from the same clock
`timescale 1ns/1ns
module ots_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ots_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ots_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [ots_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [5:0] monitored_voltage_primary_ok,
  input wire logic [5:0] monitored_voltage_secondary_ok,
  input wire logic logic_input_a,
  input wire logic logic_input_b,
  input wire logic logic_input_c,
  input wire logic logic_input_d,
  input wire logic manual_reset_n,
  input wire logic watchdog_one_expired,
  input wire logic watchdog_two_expired,
  input wire logic sequenced_output_one,
  input wire logic sequenced_output_two,
  input wire logic sequenced_output_four,
  input wire logic sequenced_output_five,
  input wire logic sequenced_output_six,
  input wire logic sequenced_output_seven,
  input wire logic sequenced_output_eight,
  input wire logic term_two_true,
  output logic term_one_true,
  output logic sequenced_output_three
);
  typedef enum logic [2:0] {
    OTS_IDLE,
    OTS_NV_RD,
    OTS_ACK,
    OTS_LD_RD,
    OTS_LD_WR
  } ots_state_t;

  ots_state_t state_q;
  ots_state_t state_d;
  logic [ots_pkg::REG_W-1:0] sel_a_q;
  logic [ots_pkg::REG_W-1:0] sel_a_d;
  logic [ots_pkg::REG_W-1:0] sel_b_q;
  logic [ots_pkg::REG_W-1:0] sel_b_d;
  logic [ots_pkg::REG_W-1:0] sel_c_q;
  logic [ots_pkg::REG_W-1:0] sel_c_d;
  logic [ots_pkg::REG_W-1:0] sel_d_q;
  logic [ots_pkg::REG_W-1:0] sel_d_d;
  logic [ots_pkg::REG_W-1:0] mr_map_q;
  logic [ots_pkg::REG_W-1:0] mr_map_d;
  logic [ots_pkg::DATA_W-1:0] rdata_q;
  logic [ots_pkg::DATA_W-1:0] rdata_d;
  logic wait_q;
  logic wait_d;
  logic load_req_q;
  logic load_req_d;
  logic [2:0] slot_q;
  logic [2:0] slot_d;
  logic [ots_pkg::SYNC_W-1:0] sync1_q;
  logic [ots_pkg::SYNC_W-1:0] sync2_q;
  logic [ots_pkg::SYNC_W-1:0] sync1_d;
  logic term1_q;
  logic term1_d;
  logic term2_q;
  logic term2_d;
  logic out3_q;
  logic out3_d;
  logic mr_active_q;
  logic mr_active_d;

  logic [15:0] idx;
  logic is_nv;
  logic [15:0] base_idx;
  logic slot_ok;
  logic [2:0] slot_sel;
  logic nv_we;
  logic [2:0] nv_waddr;
  logic [2:0] nv_raddr;
  logic [ots_pkg::REG_W-1:0] nv_wdata;
  logic [ots_pkg::REG_W-1:0] nv_rdata;
  logic [ots_pkg::SEL_W-1:0] sel_vec;
  logic [ots_pkg::SEL_W-1:0] healthy;
  logic [5:0] prim_ok;
  logic [5:0] sec_ok;
  logic [3:0] gpi_active;
  logic mr_low;
  logic [ots_pkg::REG_W-1:0] vol_rd;
  logic wr_lane;
  logic vol_rd_req;
  logic nv_rd_req;
  logic vol_we;
  logic load_we;
  logic [ots_pkg::REG_W-1:0] status_rd;

  ots_nv_store u_nv (
    .clk(clk),
    .wr_en(nv_we),
    .wr_addr(nv_waddr),
    .wr_data(nv_wdata),
    .rd_addr(nv_raddr),
    .rd_data_q(nv_rdata)
  );

  // pins from outside the clock domain pass two flops first
  always_comb begin
    sync1_d = {manual_reset_n, logic_input_d, logic_input_c,
               logic_input_b, logic_input_a,
               monitored_voltage_secondary_ok,
               monitored_voltage_primary_ok};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync1_q;
    end
  end

  always_comb begin
    prim_ok = sync2_q[5:0];
    sec_ok = sync2_q[11:6];
    gpi_active = sync2_q[15:12];
    mr_low = ~sync2_q[16];
  end

  // address decode: byte address is four times the index
  always_comb begin
    idx = avs_address[ots_pkg::ADDR_W-1:2];
    is_nv = (idx & ots_pkg::NV_BASE) == ots_pkg::NV_BASE;
    base_idx = idx & ~ots_pkg::NV_BASE;
    wr_lane = avs_byteenable[0];
    slot_ok = 1'b1;
    slot_sel = ots_pkg::SLOT_A;
    unique case (base_idx)
      ots_pkg::IDX_SEL_A: slot_sel = ots_pkg::SLOT_A;
      ots_pkg::IDX_SEL_B: slot_sel = ots_pkg::SLOT_B;
      ots_pkg::IDX_SEL_C: slot_sel = ots_pkg::SLOT_C;
      ots_pkg::IDX_SEL_D: slot_sel = ots_pkg::SLOT_D;
      ots_pkg::IDX_MR_MAP: slot_sel = ots_pkg::SLOT_MR;
      default: slot_ok = 1'b0;
    endcase
  end

  always_comb begin
    vol_rd = '0;
    unique case (slot_sel)
      ots_pkg::SLOT_A: vol_rd = sel_a_q;
      ots_pkg::SLOT_B: vol_rd = sel_b_q;
      ots_pkg::SLOT_C: vol_rd = sel_c_q;
      ots_pkg::SLOT_D: vol_rd = sel_d_q;
      ots_pkg::SLOT_MR: vol_rd = mr_map_q;
      default: vol_rd = '0;
    endcase
  end

  // request kinds: stored copies answer one cycle later than the rest
  always_comb begin
    vol_rd_req = avs_read && !is_nv && slot_ok;
    nv_rd_req = avs_read && is_nv && slot_ok;
  end

  // write strobes act at the edge that closes the answer cycle
  always_comb begin
    vol_we = (state_q == OTS_ACK) && avs_write && wr_lane && !is_nv
             && slot_ok;
    load_we = (state_q == OTS_ACK) && avs_write && wr_lane
              && idx == ots_pkg::IDX_LOAD
              && avs_writedata[ots_pkg::LOAD_GO_BIT];
  end

  always_comb begin
    status_rd = '0;
    status_rd[ots_pkg::ST_OUT_BIT] = out3_q;
    status_rd[ots_pkg::ST_TERM1_BIT] = term1_q;
    status_rd[ots_pkg::ST_TERM2_BIT] = term2_q;
    status_rd[ots_pkg::ST_MR_BIT] = mr_active_q;
    status_rd[ots_pkg::ST_LOAD_BIT] = load_req_q;
  end

  // nonvolatile store port: loader owns the read side while loading
  always_comb begin
    nv_we = (state_q == OTS_ACK) && avs_write && wr_lane && is_nv
            && slot_ok;
    nv_waddr = slot_sel;
    nv_wdata = avs_writedata[ots_pkg::REG_W-1:0];
    nv_raddr = (state_q == OTS_LD_RD || state_q == OTS_LD_WR) ?
               slot_q : slot_sel;
  end

  // bus and loader sequencing
  always_comb begin
    state_d = state_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    load_req_d = load_req_q;
    slot_d = slot_q;
    sel_a_d = sel_a_q;
    sel_b_d = sel_b_q;
    sel_c_d = sel_c_q;
    sel_d_d = sel_d_q;
    mr_map_d = mr_map_q;
    unique case (state_q)
      OTS_IDLE: begin
        if (load_req_q) begin
          load_req_d = 1'b0;
          slot_d = ots_pkg::SLOT_A;
          state_d = OTS_LD_RD;
        end else if (nv_rd_req) begin
          state_d = OTS_NV_RD;
        end else if (avs_read || avs_write) begin
          rdata_d = '0;
          if (vol_rd_req) begin
            rdata_d[ots_pkg::REG_W-1:0] = vol_rd;
          end else if (avs_read && idx == ots_pkg::IDX_STATUS) begin
            rdata_d[ots_pkg::REG_W-1:0] = status_rd;
          end
          wait_d = 1'b0;
          state_d = OTS_ACK;
        end
      end
      OTS_NV_RD: begin
        // store read data is registered, so wait one cycle
        rdata_d = '0;
        rdata_d[ots_pkg::REG_W-1:0] = nv_rdata;
        wait_d = 1'b0;
        state_d = OTS_ACK;
      end
      OTS_ACK: begin
        if (vol_we) begin
          unique case (slot_sel)
            ots_pkg::SLOT_A: sel_a_d = avs_writedata[7:0];
            ots_pkg::SLOT_B: sel_b_d = avs_writedata[7:0];
            ots_pkg::SLOT_C: sel_c_d = avs_writedata[7:0];
            ots_pkg::SLOT_D: sel_d_d = avs_writedata[7:0];
            ots_pkg::SLOT_MR: mr_map_d = avs_writedata[7:0];
            default: sel_a_d = sel_a_q;
          endcase
        end
        if (load_we) begin
          load_req_d = 1'b1;
        end
        state_d = OTS_IDLE;
      end
      OTS_LD_RD: begin
        state_d = OTS_LD_WR;
      end
      OTS_LD_WR: begin
        // copy one word from the store into its working register
        unique case (slot_q)
          ots_pkg::SLOT_A: sel_a_d = nv_rdata;
          ots_pkg::SLOT_B: sel_b_d = nv_rdata;
          ots_pkg::SLOT_C: sel_c_d = nv_rdata;
          ots_pkg::SLOT_D: sel_d_d = nv_rdata;
          ots_pkg::SLOT_MR: mr_map_d = nv_rdata;
          default: sel_a_d = sel_a_q;
        endcase
        if (slot_q == ots_pkg::SLOT_LAST) begin
          state_d = OTS_IDLE;
        end else begin
          slot_d = 3'(slot_q + 3'h1);
          state_d = OTS_LD_RD;
        end
      end
      default: state_d = OTS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= OTS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= '0;
      load_req_q <= 1'b0;
      slot_q <= ots_pkg::SLOT_A;
      sel_a_q <= ots_pkg::SEL_A_RST;
      sel_b_q <= ots_pkg::SEL_B_RST;
      sel_c_q <= ots_pkg::SEL_C_RST;
      sel_d_q <= ots_pkg::SEL_D_RST;
      mr_map_q <= ots_pkg::MR_MAP_RST;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      load_req_q <= load_req_d;
      slot_q <= slot_d;
      sel_a_q <= sel_a_d;
      sel_b_q <= sel_b_d;
      sel_c_q <= sel_c_d;
      sel_d_q <= sel_d_d;
      mr_map_q <= mr_map_d;
    end
  end

  // select bits and healthy levels in the same order, bit 0 first
  always_comb begin
    sel_vec = {sel_d_q[0], sel_c_q, sel_b_q, sel_a_q};
    healthy[5:0] = prim_ok;
    healthy[6] = ~watchdog_one_expired;
    healthy[7] = ~watchdog_two_expired;
    healthy[13:8] = sec_ok;
    healthy[14] = ~gpi_active[0];
    healthy[15] = ~gpi_active[1];
    healthy[16] = ~gpi_active[2];
    healthy[17] = ~gpi_active[3];
    healthy[18] = ~sequenced_output_one;
    healthy[19] = ~sequenced_output_two;
    healthy[20] = ~sequenced_output_four;
    healthy[21] = ~sequenced_output_five;
    healthy[22] = ~sequenced_output_six;
    healthy[23] = ~sequenced_output_seven;
    healthy[24] = ~sequenced_output_eight;
  end

  // unselected conditions count as true; empty selection gives one
  always_comb begin
    term1_d = &(healthy | ~sel_vec);
    term2_d = term_two_true;
    mr_active_d = mr_map_q[ots_pkg::MR_MAP_BIT] & mr_low;
    out3_d = ~(term1_d | term2_d) | mr_active_d;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      term1_q <= 1'b0;
      term2_q <= 1'b0;
      out3_q <= 1'b1;
      mr_active_q <= 1'b0;
    end else begin
      term1_q <= term1_d;
      term2_q <= term2_d;
      out3_q <= out3_d;
      mr_active_q <= mr_active_d;
    end
  end

  always_comb begin
    avs_readdata = rdata_q;
    avs_waitrequest = wait_q;
    term_one_true = term1_q;
    sequenced_output_three = out3_q;
  end
endmodule

// file: verif/ots_select_chk.sv
// Purpose: port assertions for ots_select
// Assumes: one clock, synchronous active-low reset
// Notes: synchronized pins take three cycles to reach output three; term two takes one
`timescale 1ns/1ns
module ots_select_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ots_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic manual_reset_n,
  input wire logic term_two_true,
  input wire logic term_one_true,
  input wire logic sequenced_output_three
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_mr_idle;
    manual_reset_n [*4];
  endsequence
  sequence s_req_open;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_answer_bound: assert property (s_req_open |-> ##[0:16] !avs_waitrequest)
    else $error("request not answered in time");
  chk_answer_cause: assert property
    (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  chk_read_upper: assert property
    (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_data_stands: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data changed between answers");
  chk_reset_state: assert property ($past(rst_n) == 1'b0 |->
    sequenced_output_three && !term_one_true && avs_waitrequest)
    else $error("wrong state after reset");
  chk_term2_wins:
    assert property ((s_mr_idle ##0 term_two_true) |=> !sequenced_output_three)
    else $error("output three asserted while term two true");
  chk_term1_wins:
    assert property
    ((s_mr_idle ##0 term_one_true [*2]) |-> !sequenced_output_three)
    else $error("output three asserted while term one true");
  chk_both_false:
    assert property ((!term_one_true && !term_two_true) ##1 !term_one_true
    |-> sequenced_output_three)
    else $error("output three not asserted with both terms false");
endmodule

// file: verif/ots_select_tb.sv
// Purpose: self-checking bench for ots_select
// Assumes: bench drives every port itself
// Notes: conditions are driven as a 25-bit healthy vector in select order
`timescale 1ns/1ns
module ots_select_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ots_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [ots_pkg::DATA_W-1:0] avs_writedata = '0, avs_readdata, d;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, term_one_true, sequenced_output_three;
  logic [5:0] monitored_voltage_primary_ok = '1;
  logic [5:0] monitored_voltage_secondary_ok = '1;
  logic logic_input_a = '0, logic_input_b = '0;
  logic logic_input_c = '0, logic_input_d = '0;
  logic manual_reset_n = 1'b1, term_two_true = '0;
  logic watchdog_one_expired = '0, watchdog_two_expired = '0;
  logic sequenced_output_one = '0, sequenced_output_two = '0;
  logic sequenced_output_four = '0, sequenced_output_five = '0;
  logic sequenced_output_six = '0, sequenced_output_seven = '0;
  logic sequenced_output_eight = '0;
  logic [31:0] seed = 32'h01037038, r, v;
  logic [7:0] nv [5];
  logic [15:0] idx [5] = '{ots_pkg::IDX_SEL_A, ots_pkg::IDX_SEL_B,
    ots_pkg::IDX_SEL_C, ots_pkg::IDX_SEL_D, ots_pkg::IDX_MR_MAP};
  int failures = 0, check_count = 0;
  always #2 clk = ~clk;
  ots_select i_dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .monitored_voltage_primary_ok, .monitored_voltage_secondary_ok,
    .logic_input_a, .logic_input_b, .logic_input_c, .logic_input_d,
    .manual_reset_n, .watchdog_one_expired, .watchdog_two_expired,
    .sequenced_output_one, .sequenced_output_two, .sequenced_output_four,
    .sequenced_output_five, .sequenced_output_six, .sequenced_output_seven,
    .sequenced_output_eight, .term_two_true, .term_one_true,
    .sequenced_output_three);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [17:0] adr(logic [15:0] i);
    return {i, 2'h0};
  endfunction
  function automatic logic exp_out(input logic t1, input logic t2,
    input logic [7:0] map, input logic mrn);
    return !(t1 | t2) | (map[ots_pkg::MR_MAP_BIT] & !mrn);
  endfunction
  task automatic summarize();
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [17:0] a,
    input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) failures++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] x);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, x}, 4'hF, q);
  endtask
  // healthy vector h is in select bit order; term two and pin driven too
  task automatic run(input logic [24:0] s, input logic [24:0] h,
    input logic t2, input logic [7:0] map, input logic mrn);
    logic t1;
    wr(adr(idx[0]), s[7:0]);
    wr(adr(idx[1]), s[15:8]);
    wr(adr(idx[2]), s[23:16]);
    wr(adr(idx[3]), {7'h0, s[24]});
    wr(adr(idx[4]), map);
    @(posedge clk);
    monitored_voltage_primary_ok <= h[5:0];
    watchdog_one_expired <= !h[6];
    watchdog_two_expired <= !h[7];
    monitored_voltage_secondary_ok <= h[13:8];
    logic_input_a <= !h[14];
    logic_input_b <= !h[15];
    logic_input_c <= !h[16];
    logic_input_d <= !h[17];
    sequenced_output_one <= !h[18];
    sequenced_output_two <= !h[19];
    {sequenced_output_seven, sequenced_output_six, sequenced_output_five,
      sequenced_output_four} <= ~h[23:20];
    sequenced_output_eight <= !h[24];
    term_two_true <= t2;
    manual_reset_n <= mrn;
    repeat (5) @(posedge clk);
    t1 = &(~s | h);
    check({31'h0, term_one_true}, {31'h0, t1});
    check({31'h0, sequenced_output_three},
      {31'h0, exp_out(t1, t2, map, mrn)});
    bus(1'b0, adr(ots_pkg::IDX_STATUS), '0, 4'hF, d);
    check(d, {27'h0, 1'b0, map[ots_pkg::MR_MAP_BIT] & !mrn, t2, t1,
      exp_out(t1, t2, map, mrn)});
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, adr(idx[i]), '0, 4'hF, d);
      check(d, 32'h0);
      v = xs();
      wr(adr(idx[i]), v[7:0]);
      bus(1'b1, adr(idx[i]), ~v, 4'hE, d);
      bus(1'b0, adr(idx[i]), '0, 4'hF, d);
      check(d, {24'h0, v[7:0]});
    end
    bus(1'b0, adr(16'h0001), '0, 4'hF, d);
    check(d, 32'h0);
    for (int i = 0; i < 5; i++) begin
      r = xs();
      nv[i] = r[7:0];
      wr(adr(idx[i] + ots_pkg::NV_BASE), nv[i]);
      bus(1'b0, adr(idx[i] + ots_pkg::NV_BASE), '0, 4'hF, d);
      check(d, {24'h0, nv[i]});
    end
    wr(adr(ots_pkg::IDX_LOAD), 8'h01);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, adr(idx[i]), '0, 4'hF, d);
      check(d, {24'h0, nv[i]});
    end
    for (int b = 0; b < 25; b++) begin
      run(25'h1 << b, ~(25'h1 << b), 1'b0, 8'h00, 1'b1);
      run(25'h1 << b, 25'h1 << b, 1'b0, 8'h00, 1'b0);
    end
    r = xs();
    run('0, r[24:0], 1'b0, 8'h00, 1'b1);
    run('0, '0, 1'b1, 8'h04, 1'b0);
    run('0, '0, 1'b1, 8'h04, 1'b1);
    run('0, '0, 1'b1, 8'hFB, 1'b0);
    repeat (40) begin
      r = xs() & xs();
      v = xs() | xs();
      d = xs();
      seed = seed ^ 32'h5A5A5A5A;
      run(r[24:0], v[24:0], r[31] & v[31], d[7:0], seed[3]);
    end
    run(r[24:0] & 25'h0F3CFCF, v[24:0], 1'b0, 8'h00, 1'b1);
    summarize();
  end
endmodule
bind ots_select ots_select_chk i_chk (.clk, .rst_n, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .manual_reset_n, .term_two_true,
  .term_one_true, .sequenced_output_three);
